// *** dac_diag_map.svh ***
// Register offsets, field positions, codes, reset values and timing counts of the diagnosis block
`ifndef DAC_DIAG_MAP_SVH
`define DAC_DIAG_MAP_SVH

// ----------------------------------------
// APB register offsets (byte addresses)
// ----------------------------------------
`define DAC_OFF_CTRL      12'h000
`define DAC_OFF_STATUS    12'h004
`define DAC_OFF_HIST      12'h008
`define DAC_OFF_LASTERR   12'h00C
`define DAC_OFF_TABLE     12'h040
`define DAC_TABLE_SPAN    12'h040

// ----------------------------------------
// Register fields and reset values
// ----------------------------------------
`define DAC_CTRL_BUSY_BIT 0
`define DAC_ST_BUSY_BIT   0
`define DAC_ST_PROT_BIT   1
`define DAC_ST_EXT_BIT    2
`define DAC_HIST_B5_LSB   0
`define DAC_HIST_B6_LSB   8
`define DAC_CTRL_RST      1'b0
`define DAC_PROT_RST      1'b0
`define DAC_LASTERR_RST   8'h00

// ----------------------------------------
// Parameter table entry fields
// ----------------------------------------
`define DAC_TE_VALID      31
`define DAC_TE_RO         30
`define DAC_TE_SLOT_LSB   16
`define DAC_TE_INDEX_LSB  8
`define DAC_TE_SIZE_LSB   0
`define DAC_TE_MIN_LSB    0
`define DAC_TE_MAX_LSB    16

// ----------------------------------------
// Historical diagnosis bit positions
// ----------------------------------------
`define DAC_B6_OUTP       7
`define DAC_B6_SUPPLY     6
`define DAC_B6_AUTOST     5
`define DAC_B6_CTRLDEV    4
`define DAC_B6_LOWLOW     3
`define DAC_B6_HIGHHIGH   2
`define DAC_B6_LOW        1
`define DAC_B6_HIGH       0
`define DAC_B5_TEMP       0

// ----------------------------------------
// Error byte: class and codes
// ----------------------------------------
`define DAC_CLASS_ACCESS  4'hB
`define DAC_CODE_INDEX    4'h0
`define DAC_CODE_LENGTH   4'h1
`define DAC_CODE_SLOT     4'h2
`define DAC_CODE_BUSY     4'h5
`define DAC_CODE_DENIED   4'h6
`define DAC_CODE_RANGE    4'h7
`define DAC_CODE_RDONLY   4'hA
`define DAC_CODE_OTHER    4'hF
`define DAC_RESTORE_VALUE 16'h8000

// ----------------------------------------
// Timing
// ----------------------------------------
`define DAC_CLK_MHZ       25
`define DAC_BUSY_US       100
`define DAC_BUSY_CYCLES   (`DAC_BUSY_US * `DAC_CLK_MHZ)

`endif

// *** dac_diag_pkg.sv ***
// Types shared by the diagnosis and acyclic error code block
package dac_diag_pkg;

	// Process conditions, one level each
	typedef struct packed {
		logic out_press_bad;
		logic supply_low;
		logic autostart_fail;
		logic ctrl_dev_lim;
		logic pos_lowlow;
		logic pos_highhigh;
		logic pos_low;
		logic pos_high;
		logic temp_over;
	} dac_cond_t;

	// One acyclic read or write request
	typedef struct packed {
		logic        is_write;
		logic [7:0]  slot;
		logic [7:0]  index;
		logic [7:0]  length;
		logic [15:0] value;
	} dac_req_t;

	// Answer to one request
	typedef struct packed {
		logic       ok;
		logic [7:0] err;
	} dac_resp_t;

	// Request sequencer, one bit changes per step except RESP back to IDLE
	typedef enum logic [1:0] {
		DAC_IDLE  = 2'b00,
		DAC_CHECK = 2'b01,
		DAC_RESP  = 2'b11
	} dac_state_t;

endpackage : dac_diag_pkg

// *** dac_diag_top.sv ***
// Historical process diagnosis and acyclic parameter access checker with APB registers
`timescale 1ns/10ps
`include "dac_diag_map.svh"

module dac_diag_top
	import dac_diag_pkg::*;
#(
	parameter int         TBL_N       = 8,
	parameter logic [11:0] BUSY_CYCLES = 12'(`DAC_BUSY_CYCLES),
	parameter logic [7:0] WP_SLOT     = 8'h01,
	parameter logic [7:0] WP_INDEX    = 8'h10,
	parameter logic [7:0] RST_SLOT    = 8'h01,
	parameter logic [7:0] RST_INDEX   = 8'h11
) (
	// Clock and reset
	input  wire logic  ref_clk,
	input  wire logic  resetn,
	// APB slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// Process conditions
	input  wire dac_cond_t    cond,
	// Acyclic request from the fieldbus side
	input  wire logic         req_valid,
	input  wire dac_req_t     req,
	output logic              req_ready,
	// Answer to the fieldbus side
	output logic              resp_valid,
	output dac_resp_t         resp,
	// Diagnosis outputs
	output logic [7:0]        hist_byte5,
	output logic [7:0]        hist_byte6,
	output logic              ext_avail,
	output logic              write_protect
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	// Asynchronous assert, synchronous release
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [31:0] tbl_w0_reg [TBL_N];
	logic [31:0] tbl_w1_reg [TBL_N];
	logic        ctrl_busy_reg;
	logic        protect_reg;
	logic        ext_reg;
	logic [7:0]  last_err_reg;
	logic [11:0] busy_cnt_reg;
	logic [31:0] rdata_reg;
	logic        bad_addr_reg;
	dac_state_t  state_reg;
	dac_req_t    req_q_reg;
	dac_resp_t   resp_reg;
	logic [15:0] hist_set;
	logic [15:0] hist_q;
	logic        hist_clr;
	logic        busy;
	logic        apb_setup;
	logic        apb_wr;
	logic        in_table;
	logic [TBL_N-1:0] slot_m;
	logic [TBL_N-1:0] idx_m;
	logic [TBL_N-1:0] hit_m;
	logic [31:0] sel_w0;
	logic [31:0] sel_w1;
	logic        is_wp;
	logic        is_rst;
	logic        chk_fail;
	logic [7:0]  chk_err;
	logic        do_write;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Zero wait states; read data is prepared in the setup cycle
	assign pready    = 1'b1;
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pwrite;
	assign pslverr   = psel & penable & bad_addr_reg;
	assign prdata    = rdata_reg;
	assign in_table  = (paddr >= `DAC_OFF_TABLE) && (paddr < (`DAC_OFF_TABLE + `DAC_TABLE_SPAN))
	                   && (paddr[1:0] == 2'b00);

	// Read data and address check, latched in the setup cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg    <= 32'h0000_0000;
			bad_addr_reg <= 1'b0;
		end else if (apb_setup) begin
			rdata_reg    <= 32'h0000_0000;
			bad_addr_reg <= 1'b0;
			if (paddr == `DAC_OFF_CTRL) begin
				rdata_reg[`DAC_CTRL_BUSY_BIT] <= ctrl_busy_reg;
			end else if (paddr == `DAC_OFF_STATUS) begin
				rdata_reg[`DAC_ST_BUSY_BIT] <= busy;
				rdata_reg[`DAC_ST_PROT_BIT] <= protect_reg;
				rdata_reg[`DAC_ST_EXT_BIT]  <= ext_reg;
			end else if (paddr == `DAC_OFF_HIST) begin
				rdata_reg[15:0] <= hist_q;
			end else if (paddr == `DAC_OFF_LASTERR) begin
				rdata_reg[7:0] <= last_err_reg;
			end else if (in_table) begin
				rdata_reg <= paddr[2] ? tbl_w1_reg[paddr[5:3]] : tbl_w0_reg[paddr[5:3]];
			end else begin
				bad_addr_reg <= 1'b1;
			end
		end
	end

	// Software busy flag; lets firmware hold off acyclic traffic
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_busy_reg <= `DAC_CTRL_RST;
		end else if (apb_wr && paddr == `DAC_OFF_CTRL) begin
			ctrl_busy_reg <= pwdata[`DAC_CTRL_BUSY_BIT];
		end
	end

	// Parameter directory, two words per entry
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int e = 0; e < TBL_N; e++) begin
				tbl_w0_reg[e] <= 32'h0000_0000;
				tbl_w1_reg[e] <= 32'h0000_0000;
			end
		end else if (apb_wr && in_table) begin
			if (paddr[2]) begin
				tbl_w1_reg[paddr[5:3]] <= pwdata;
			end else begin
				tbl_w0_reg[paddr[5:3]] <= pwdata;
			end
		end
	end

	// ----------------------------------------
	// Busy window after reset
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt_reg <= 12'h000;
		end else if (busy_cnt_reg != BUSY_CYCLES) begin
			busy_cnt_reg <= busy_cnt_reg + 12'h001;
		end
	end
	assign busy = (busy_cnt_reg != BUSY_CYCLES) | ctrl_busy_reg;

	// ----------------------------------------
	// Historical diagnosis
	// ----------------------------------------
	// Bits of bytes 5 not driven here stay clear
	always_comb begin
		hist_set = 16'h0000;
		hist_set[`DAC_HIST_B6_LSB + `DAC_B6_OUTP]     = cond.out_press_bad;
		hist_set[`DAC_HIST_B6_LSB + `DAC_B6_SUPPLY]   = cond.supply_low;
		hist_set[`DAC_HIST_B6_LSB + `DAC_B6_AUTOST]   = cond.autostart_fail;
		hist_set[`DAC_HIST_B6_LSB + `DAC_B6_CTRLDEV]  = cond.ctrl_dev_lim;
		hist_set[`DAC_HIST_B6_LSB + `DAC_B6_LOWLOW]   = cond.pos_lowlow;
		hist_set[`DAC_HIST_B6_LSB + `DAC_B6_HIGHHIGH] = cond.pos_highhigh;
		hist_set[`DAC_HIST_B6_LSB + `DAC_B6_LOW]      = cond.pos_low;
		hist_set[`DAC_HIST_B6_LSB + `DAC_B6_HIGH]     = cond.pos_high;
		hist_set[`DAC_HIST_B5_LSB + `DAC_B5_TEMP]     = cond.temp_over;
	end

	dac_hist_latch #(
		.W     (16)
	) u_hist (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.set   (hist_set),
		.clr   (hist_clr),
		.q     (hist_q)
	);

	// Extension flag follows any new historical event; set beats clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_reg <= 1'b0;
		end else begin
			ext_reg <= (|hist_set) | (ext_reg & ~hist_clr);
		end
	end

	assign hist_byte5    = hist_q[`DAC_HIST_B5_LSB +: 8];
	assign hist_byte6    = hist_q[`DAC_HIST_B6_LSB +: 8];
	assign ext_avail     = ext_reg;
	assign write_protect = protect_reg;

	// ----------------------------------------
	// Parameter lookup
	// ----------------------------------------
	for (genvar e = 0; e < TBL_N; e++) begin : g_match
		assign slot_m[e] = tbl_w0_reg[e][`DAC_TE_VALID]
		                   && (tbl_w0_reg[e][`DAC_TE_SLOT_LSB +: 8] == req_q_reg.slot);
		assign idx_m[e]  = tbl_w0_reg[e][`DAC_TE_VALID]
		                   && (tbl_w0_reg[e][`DAC_TE_INDEX_LSB +: 8] == req_q_reg.index);
		assign hit_m[e]  = slot_m[e] & idx_m[e];
	end

	// Duplicate entries: the highest numbered one is used
	always_comb begin
		sel_w0 = 32'h0000_0000;
		sel_w1 = 32'h0000_0000;
		for (int e = 0; e < TBL_N; e++) begin
			if (hit_m[e]) begin
				sel_w0 = tbl_w0_reg[e];
				sel_w1 = tbl_w1_reg[e];
			end
		end
	end

	assign is_wp  = (req_q_reg.slot == WP_SLOT) && (req_q_reg.index == WP_INDEX);
	assign is_rst = (req_q_reg.slot == RST_SLOT) && (req_q_reg.index == RST_INDEX);

	// Checks in fixed order; a known index in a slot used only by other entries falls to other
	dac_err_encode u_enc (
		.busy      (busy),
		.idx_bad   (~|idx_m),
		.slot_bad  (~|slot_m),
		.len_bad   (req_q_reg.is_write && (|hit_m)
		            && (req_q_reg.length != sel_w0[`DAC_TE_SIZE_LSB +: 8])),
		.ro_bad    (req_q_reg.is_write && sel_w0[`DAC_TE_RO]),
		.prot_bad  (req_q_reg.is_write && protect_reg && !is_wp),
		.rng_bad   (req_q_reg.is_write && (|hit_m)
		            && ((req_q_reg.value < sel_w1[`DAC_TE_MIN_LSB +: 16])
		            || (req_q_reg.value > sel_w1[`DAC_TE_MAX_LSB +: 16]))),
		.other_bad (~|hit_m),
		.fail      (chk_fail),
		.err_byte  (chk_err)
	);

	assign do_write = (state_reg == DAC_CHECK) && !chk_fail && req_q_reg.is_write;
	assign hist_clr = do_write && is_rst && (req_q_reg.value == `DAC_RESTORE_VALUE);

	// ----------------------------------------
	// Request sequencer
	// ----------------------------------------
	assign req_ready  = (state_reg == DAC_IDLE);
	assign resp_valid = (state_reg == DAC_RESP);
	assign resp       = resp_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= DAC_IDLE;
		end else begin
			case (state_reg)
				DAC_IDLE: begin
					if (req_valid) begin
						state_reg <= DAC_CHECK;
					end
				end
				DAC_CHECK: begin
					state_reg <= DAC_RESP;
				end
				default: begin
					state_reg <= DAC_IDLE;
				end
			endcase
		end
	end

	// Request copy stays stable while it is checked
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_q_reg <= '0;
		end else if (req_ready && req_valid) begin
			req_q_reg <= req;
		end
	end

	// Answer and last error kept for software
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			resp_reg     <= '0;
			last_err_reg <= `DAC_LASTERR_RST;
		end else if (state_reg == DAC_CHECK) begin
			resp_reg.ok  <= !chk_fail;
			resp_reg.err <= chk_err;
			if (chk_fail) begin
				last_err_reg <= chk_err;
			end
		end
	end

	// Protection is changed only by an accepted write to its own parameter
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			protect_reg <= `DAC_PROT_RST;
		end else if (do_write && is_wp) begin
			protect_reg <= (req_q_reg.value != 16'h0000);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_OUTP_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hist_byte6[`DAC_B6_OUTP] && !hist_clr |=> hist_byte6[`DAC_B6_OUTP])
		else $error("output pressure bit dropped");
	AST_SUPPLY_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cond.supply_low |=> hist_byte6[`DAC_B6_SUPPLY] && ext_avail)
		else $error("supply low not latched");
	AST_AUTOST_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cond.autostart_fail ##1 !hist_clr |=> hist_byte6[`DAC_B6_AUTOST])
		else $error("autostart bit not held");
	AST_CTRLDEV_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(cond.ctrl_dev_lim) |=> hist_byte6[`DAC_B6_CTRLDEV])
		else $error("deviation bit not latched");
	AST_LOWLOW_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cond.pos_lowlow |=> hist_byte6[`DAC_B6_LOWLOW])
		else $error("low-low bit not latched");
	AST_HIGHHIGH_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cond.pos_highhigh |=> hist_byte6[`DAC_B6_HIGHHIGH])
		else $error("high-high bit not latched");
	AST_LOWHIGH_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cond.pos_low && !cond.pos_high |=> hist_byte6[`DAC_B6_LOW] && ($past(hist_byte6[`DAC_B6_HIGH])
		|| !hist_byte6[`DAC_B6_HIGH] || $past(hist_clr)))
		else $error("low or high bit wrong");
	AST_TEMP_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cond.temp_over |=> hist_byte5[`DAC_B5_TEMP])
		else $error("temperature bit not latched");
	AST_RESP_TIMING: assert property (@(posedge ref_clk) disable iff (!rst_n)
		req_valid && req_ready |=> !resp_valid ##1 resp_valid ##1 !resp_valid)
		else $error("answer not two cycles after acceptance");
	AST_ERR_CLASS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		resp_valid && !resp.ok |-> resp.err[7:4] == 4'hB)
		else $error("error class not access");
	AST_BUSY_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_reg == DAC_CHECK && busy |=> resp_valid && !resp.ok && resp.err == 8'hB5)
		else $error("busy did not answer state conflict");
	AST_UNUSED_CODES: assert property (@(posedge ref_clk) disable iff (!rst_n)
		resp_valid && !resp.ok |-> !(resp.err[3:0] inside {4'h3, 4'h4, 4'h8, 4'h9, [4'hB:4'hE]}))
		else $error("unused access code emitted");
	AST_RESTORE_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hist_clr |=> hist_q == $past(hist_set) && ext_avail == (|$past(hist_set)))
		else $error("restore did not clear history");
	AST_PROTECT_REFUSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_reg == DAC_CHECK && protect_reg && req_q_reg.is_write && !is_wp |=> !resp.ok)
		else $error("write passed under protection");

endmodule : dac_diag_top

// *** dac_err_encode.sv ***
// Priority encoder for the acyclic access error byte
`timescale 1ns/10ps
`include "dac_diag_map.svh"
module dac_err_encode
	import dac_diag_pkg::*;
(
	// Failure conditions of one request
	input  wire logic busy,
	input  wire logic idx_bad,
	input  wire logic slot_bad,
	input  wire logic len_bad,
	input  wire logic ro_bad,
	input  wire logic prot_bad,
	input  wire logic rng_bad,
	input  wire logic other_bad,
	// Result
	output logic       fail,
	output logic [7:0] err_byte
);
	// First matching condition wins; only one code per request
	always_comb begin
		fail     = 1'b1;
		err_byte = {`DAC_CLASS_ACCESS, `DAC_CODE_OTHER};
		if (busy) begin
			err_byte = {`DAC_CLASS_ACCESS, `DAC_CODE_BUSY};
		end else if (idx_bad) begin
			err_byte = {`DAC_CLASS_ACCESS, `DAC_CODE_INDEX};
		end else if (slot_bad) begin
			err_byte = {`DAC_CLASS_ACCESS, `DAC_CODE_SLOT};
		end else if (len_bad) begin
			err_byte = {`DAC_CLASS_ACCESS, `DAC_CODE_LENGTH};
		end else if (ro_bad) begin
			err_byte = {`DAC_CLASS_ACCESS, `DAC_CODE_RDONLY};
		end else if (prot_bad) begin
			err_byte = {`DAC_CLASS_ACCESS, `DAC_CODE_DENIED};
		end else if (rng_bad) begin
			err_byte = {`DAC_CLASS_ACCESS, `DAC_CODE_RANGE};
		end else if (!other_bad) begin
			fail     = 1'b0;
			err_byte = 8'h00;
		end
	end
endmodule : dac_err_encode

// *** dac_fb_master.sv ***
// Behavioural fieldbus master issuing acyclic parameter reads and writes
`timescale 1ns/10ps
module dac_fb_master
	import dac_diag_pkg::*;
(
	// Clock
	input  wire logic      ref_clk,
	// Request to the device
	output dac_req_t       req,
	output logic           req_valid,
	input  wire logic      req_ready,
	// Answer from the device
	input  wire logic      resp_valid,
	input  wire dac_resp_t resp
);
	// Idle at time zero
	initial begin
		req_valid = 1'b0;
		req       = '0;
	end

	// Hold the request until taken; afterwards show the inverse so a stale copy is never mistaken for live data
	task automatic issue(input dac_req_t r, output dac_resp_t o);
		o = '{ok: 1'b0, err: 8'hEE};
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req       <= r;
		do @(posedge ref_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		req       <= ~r;
		// Bounded wait, a lost answer shows up as 0xEE
		for (int n = 0; n < 8; n++) begin
			@(posedge ref_clk);
			if (resp_valid === 1'b1) begin
				o = resp;
				break;
			end
		end
	endtask : issue
endmodule : dac_fb_master

// *** dac_hist_latch.sv ***
// Sticky diagnosis bits with a common clear
`timescale 1ns/10ps
`include "dac_diag_map.svh"
module dac_hist_latch
	import dac_diag_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Events and clear
	input  wire logic [W-1:0] set,
	input  wire logic         clr,
	// Held bits
	output logic [W-1:0]      q
);
	// One sticky bit each; a set in the clear cycle survives
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				q[i] <= 1'b0;
			end else begin
				q[i] <= set[i] | (q[i] & ~clr);
			end
		end
	end
endmodule : dac_hist_latch

// *** diag_and_acyclic_error_codes_tb_top.sv ***
// Self-checking testbench for the diagnosis and acyclic error code block
`timescale 1ns/10ps
`include "dac_diag_map.svh"
module diag_and_acyclic_error_codes_tb_top
	import dac_diag_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        resetn  = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	dac_cond_t   cond    = '0;
	logic [31:0] prdata;
	logic        pready, pslverr, req_valid, req_ready, resp_valid, ext_avail, write_protect;
	dac_req_t    req;
	dac_resp_t   resp;
	logic [7:0]  hist_byte5, hist_byte6;
	int          n_fail       = 0;
	int          total_checks = 0;
	int          cyc          = 0;

	always #20 ref_clk = ~ref_clk;

	// Short busy window keeps the run brief
	dac_diag_top #(.BUSY_CYCLES(12'h008)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cond(cond), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .hist_byte5(hist_byte5),
		.hist_byte6(hist_byte6), .ext_avail(ext_avail), .write_protect(write_protect));

	dac_fb_master i_master (.ref_clk(ref_clk), .req(req), .req_valid(req_valid), .req_ready(req_ready),
		.resp_valid(resp_valid), .resp(resp));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer; the global cycle limit ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp);
	endtask : rdc

	// One acyclic request, answer compared as {ok, err}
	task automatic acc(input logic w, input logic [7:0] s, input logic [7:0] i, input logic [7:0] l,
		input logic [15:0] v, input logic [8:0] exp);
		dac_resp_t r;
		i_master.issue('{w, s, i, l, v}, r);
		chk({23'h0, r}, {23'h0, exp});
	endtask : acc

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_busy;
		repeat (2) @(posedge ref_clk);
		acc(1'b0, 8'h01, 8'h10, 8'h02, 16'h0, 9'h0B5);
		repeat (12) @(posedge ref_clk);
		rdc(`DAC_OFF_LASTERR, 32'hB5);
		rdc(`DAC_OFF_STATUS, 32'h0);
		$display("test busy done");
	endtask : t_busy

	// Entries: protect, restore, read-only, ranged 10..20; rest empty
	task automatic t_table;
		logic [31:0] w0 [4] = '{32'h8001_1002, 32'h8001_1102, 32'hC001_2001, 32'h8002_3002};
		logic [31:0] w1 [4] = '{32'hFFFF_0000, 32'hFFFF_0000, 32'hFFFF_0000, 32'h0014_000A};
		logic [31:0] q;
		logic        e;
		for (int k = 0; k < 8; k++) begin
			wr(`DAC_OFF_TABLE + 12'(8 * k), (k < 4) ? w0[k % 4] : 32'h0);
			wr(`DAC_OFF_TABLE + 12'(8 * k + 4), (k < 4) ? w1[k % 4] : 32'h0);
		end
		apb(1'b0, 12'h100, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		$display("test table done");
	endtask : t_table

	task automatic t_errors;
		acc(1'b0, 8'h01, 8'h63, 8'h02, 16'h0, 9'h0B0);
		acc(1'b0, 8'h05, 8'h10, 8'h02, 16'h0, 9'h0B2);
		acc(1'b1, 8'h02, 8'h30, 8'h01, 16'hF, 9'h0B1);
		acc(1'b1, 8'h01, 8'h20, 8'h01, 16'h1, 9'h0BA);
		acc(1'b1, 8'h02, 8'h30, 8'h02, 16'h15, 9'h0B7);
		acc(1'b1, 8'h02, 8'h30, 8'h02, 16'h9, 9'h0B7);
		acc(1'b1, 8'h02, 8'h10, 8'h02, 16'h0, 9'h0BF);
		acc(1'b1, 8'h05, 8'h63, 8'h09, 16'h0, 9'h0B0);
		acc(1'b1, 8'h01, 8'h20, 8'h02, 16'h1, 9'h0B1);
		acc(1'b1, 8'h02, 8'h30, 8'h02, 16'h14, 9'h100);
		acc(1'b0, 8'h01, 8'h20, 8'h09, 16'h0, 9'h100);
		wr(`DAC_OFF_CTRL, 32'h1);
		acc(1'b0, 8'h01, 8'h20, 8'h01, 16'h0, 9'h0B5);
		wr(`DAC_OFF_CTRL, 32'h0);
		$display("test errors done");
	endtask : t_errors

	task automatic t_protect;
		acc(1'b1, 8'h01, 8'h10, 8'h02, 16'h1, 9'h100);
		@(negedge ref_clk);
		chk({31'h0, write_protect}, 32'h1);
		acc(1'b1, 8'h02, 8'h30, 8'h02, 16'hF, 9'h0B6);
		acc(1'b1, 8'h02, 8'h30, 8'h01, 16'hF, 9'h0B1);
		acc(1'b1, 8'h01, 8'h20, 8'h01, 16'h0, 9'h0BA);
		acc(1'b1, 8'h01, 8'h11, 8'h02, 16'h8000, 9'h0B6);
		acc(1'b1, 8'h01, 8'h10, 8'h02, 16'h0, 9'h100);
		@(negedge ref_clk);
		chk({31'h0, write_protect}, 32'h0);
		$display("test protect done");
	endtask : t_protect

	// Pulse each condition for one cycle; the bits must stay after it ends
	task automatic t_hist;
		logic [8:0] exp = '0;
		for (int i = 8; i >= 0; i--) begin
			@(posedge ref_clk);
			cond <= dac_cond_t'(9'h1 << i);
			@(posedge ref_clk);
			cond <= '0;
			exp[i] = 1'b1;
			repeat (2) @(negedge ref_clk);
			chk({hist_byte6, hist_byte5}, {exp[8:1], 7'h0, exp[0]});
		end
		chk({31'h0, ext_avail}, 32'h1);
		acc(1'b1, 8'h01, 8'h11, 8'h02, 16'h7FFF, 9'h100);
		rdc(`DAC_OFF_HIST, 32'hFF01);
		acc(1'b1, 8'h01, 8'h11, 8'h02, 16'h8000, 9'h100);
		@(negedge ref_clk);
		chk({hist_byte6, hist_byte5, 7'h0, ext_avail}, 32'h0);
		$display("test history done");
	endtask : t_hist

	// Cycle limit well above the expected run
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			results();
		end
	end

	initial begin
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		t_busy();
		t_table();
		t_errors();
		t_protect();
		t_hist();
		results();
	end
endmodule : diag_and_acyclic_error_codes_tb_top
